// ---- hdl/lpoh_regs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts for
//          the line and path overhead monitor.
// Assumes: Word index times four gives the Avalon byte address.
// Notes:   Definitions only.
// Behaviour
// - Count line parity errors in 20 bits, three registers
// - Counter-address write snapshots counts, restarts accumulators
// - Count line far-end errors likewise, three registers
// - Meter-load strobe polls both line counters
// - Remote-defect bit forces K2 low bits 110
// - Parity-corrupt bit inverts every outgoing B2
// - Status shows live defect, AIS, pointer-lost states
// - Path parity and far-error events set flags
// - Alarm state changes set their flags
// - Captured label change sets label flag
// - Reading flags register clears flags and interrupt
// - Far-error enable routes far-error flag to interrupt
// - Parity enable routes parity flag to interrupt
// - Defect and AIS enables route changes to interrupt
// - Pointer-lost enable routes change to interrupt
// - Label enable routes label change to interrupt
// - Label replaced after three identical consecutive frames
// - Per-frame mode counts line parity once per errored frame
`ifndef LPOH_REGS_SVH
`define LPOH_REGS_SVH

// Register word indices
`define IDX_LINE_PAR_LOW 8'h1a
`define IDX_LINE_PAR_MID 8'h1b
`define IDX_LINE_PAR_HIGH 8'h1c
`define IDX_LINE_FAR_LOW 8'h1d
`define IDX_LINE_FAR_MID 8'h1e
`define IDX_LINE_FAR_HIGH 8'h1f
`define IDX_RX_LINE_CTRL 8'h18
`define IDX_TX_LINE_CTRL 8'h20
`define IDX_TX_LINE_DIAG 8'h21
`define IDX_PATH_STATUS 8'h30
`define IDX_PATH_FLAGS 8'h31
`define IDX_PATH_FLAG_CLEAR 8'h32
`define IDX_PATH_ENABLE 8'h33
`define IDX_PATH_LABEL 8'h37

// Field positions
`define FLD_PER_FRAME_MODE 7
`define FLD_TX_REMOTE_DEFECT 0
`define FLD_PARITY_CORRUPT 0
`define FLD_PATH_FAR 0
`define FLD_PATH_PARITY 1
`define FLD_PATH_RDI 2
`define FLD_PATH_AIS 3
`define FLD_POINTER_LOST 5
`define FLD_LABEL 7
`define PATH_FLAG_MASK 8'haf

// Reset values
`define RST_ENABLE 8'h00
`define RST_CTRL_BIT 1'b0
`define RST_LABEL 8'h00

// Coding and timing
`define RDI_K2_CODE 3'h6
`define LABEL_FRAMES 2'h3
`define CLK_PERIOD_NS 100
`define LOAD_TIME_NS 7000
`define LOAD_CYCLES (`LOAD_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- hdl/lpoh_pkg.sv ----
// Purpose: Types shared by the overhead monitor files.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in lpoh_regs.svh.
package lpoh_pkg;
	// Register bus handshake state
	typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
	// One register byte
	typedef logic [7:0] reg_byte_t;
endpackage

// ---- hdl/error_accumulator.sv ----
// Purpose: Saturating error accumulator with snapshot on poll.
// Assumes: Increment and poll are synchronous to clk.
// Notes:   A poll folds the same-cycle increment into the snapshot.
`timescale 1ns/10ps
`default_nettype none
module error_accumulator
#(
	parameter int W = 20,
	parameter int IW = 5
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Events
	input wire logic [IW-1:0] inc,
	input wire logic poll,
	// Readable snapshot
	output logic [W-1:0] snapshot
);
	logic [W-1:0] acc_reg; // Running accumulator
	logic [W-1:0] snap_reg; // Value software reads
	logic [W:0] sum_wide; // Accumulator plus increment, with carry
	logic [W-1:0] total; // Saturated sum

	assign sum_wide = {1'b0, acc_reg} + {{(W+1-IW){1'b0}}, inc};
	// Saturate rather than wrap so a long interval never reads small
	assign total = sum_wide[W] ? {W{1'b1}} : sum_wide[W-1:0];
	assign snapshot = snap_reg;

	// Accumulate; coincident errors go into the snapshot, not lost
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			acc_reg <= '0;
		else if (poll)
			acc_reg <= '0;
		else
			acc_reg <= total;
	end

	// Snapshot transfer on poll
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			snap_reg <= '0;
		else if (poll)
			snap_reg <= total;
	end

	chk_snap_load: assert property (@(posedge clk) disable iff (!rst_n)
		poll |=> (snap_reg == $past(total)) && (acc_reg == '0))
		else $error("snapshot not loaded or accumulator not restarted");
	chk_acc_holds: assert property (@(posedge clk) disable iff (!rst_n)
		(!poll && inc == '0) |=> acc_reg == $past(acc_reg))
		else $error("accumulator moved without errors");
endmodule // error_accumulator
`default_nettype wire

// ---- hdl/sonet_line_path_oh_monitor.sv ----
// Purpose: Line error counters, transmit line overhead controls and
//          receive path alarm, event and label reporting.
// Assumes: Avalon-MM slave, 8-bit registers in the low byte lanes.
// Notes:   Every request takes one wait state.
`timescale 1ns/10ps
`default_nettype none
`include "lpoh_regs.svh"
module sonet_line_path_oh_monitor
#(
	parameter int CNT_W = 20,
	parameter int INC_W = 5
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Avalon-MM slave
	input wire logic [9:0] AV_ADDRESS,
	input wire logic AV_READ,
	input wire logic AV_WRITE,
	input wire logic [31:0] AV_WRITEDATA,
	input wire logic [3:0] AV_BYTEENABLE,
	output logic [31:0] AV_READDATA,
	output logic AV_WAITREQUEST,
	output logic IRQ,
	// Device-wide meter load strobe
	input wire logic METER_LOAD,
	// Receive line overhead, valid with FRAME_PULSE
	input wire logic FRAME_PULSE,
	input wire logic [INC_W-1:0] LINE_PARITY_ERRS,
	input wire logic [INC_W-1:0] LINE_FAR_ERRS,
	// Receive path overhead
	input wire logic PATH_PARITY_ERR,
	input wire logic PATH_FAR_ERR,
	input wire logic PATH_REMOTE_DEFECT_STATE,
	input wire logic PATH_ALARM_STATE,
	input wire logic POINTER_LOST_STATE,
	input wire logic [7:0] RX_LABEL,
	// Transmit line overhead
	input wire logic [7:0] TX_K2_IN,
	input wire logic [7:0] TX_B2_IN,
	output logic [7:0] TX_K2_OUT,
	output logic [7:0] TX_B2_OUT
);
	logic rst_meta_reg; // Reset synchroniser, first stage
	logic rst_n_reg; // Reset synchroniser, released copy
	lpoh_pkg::bus_state_t bus_state_reg; // Bus handshake state
	lpoh_pkg::bus_state_t bus_state_next;
	logic bus_req; // Read or write pending
	logic bus_accept; // Request completes this cycle
	logic [7:0] idx; // Word index of the access
	logic idx_ok; // Address word aligned
	lpoh_pkg::reg_byte_t read_mux; // Selected register value
	logic [31:0] readdata_reg; // Registered read data
	logic [7:0] read_snap_reg; // Flags seen by the pending read
	logic wr_accept; // Accepted write with low lane enabled
	logic rd_flags; // Accepted read of the flags register
	logic per_frame_mode_reg; // One parity count per errored frame
	logic tx_rdi_reg; // Force remote defect code in K2
	logic corrupt_reg; // Invert outgoing B2
	lpoh_pkg::reg_byte_t enable_reg; // Interrupt enables
	lpoh_pkg::reg_byte_t flags_reg; // Sticky event flags
	lpoh_pkg::reg_byte_t events; // Events this cycle
	logic rdi_prev_reg; // Previous alarm states
	logic ais_prev_reg;
	logic lop_prev_reg;
	lpoh_pkg::reg_byte_t captured_reg; // Readable signal label
	lpoh_pkg::reg_byte_t cand_reg; // Label being watched
	logic [1:0] run_reg; // Frames the candidate has repeated
	logic label_update; // Captured label takes a new value
	logic counter_poll; // Poll both line counters
	logic [INC_W-1:0] parity_inc; // Line parity increment
	logic [INC_W-1:0] far_inc; // Line far-error increment
	logic [CNT_W-1:0] parity_snap; // Line parity snapshot
	logic [CNT_W-1:0] far_snap; // Line far-error snapshot

	// Two-stage reset release; the assert stays asynchronous
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// Bus decode; a misaligned address counts as unmapped
	assign bus_req = AV_READ | AV_WRITE;
	assign idx = AV_ADDRESS[9:2];
	assign idx_ok = (AV_ADDRESS[1:0] == 2'h0);
	assign bus_accept = bus_req && (bus_state_reg == lpoh_pkg::BUS_ACK);
	assign AV_WAITREQUEST = bus_req && (bus_state_reg != lpoh_pkg::BUS_ACK);
	assign AV_READDATA = readdata_reg;
	assign wr_accept = bus_accept && AV_WRITE && idx_ok && AV_BYTEENABLE[0];
	assign rd_flags = bus_accept && AV_READ && idx_ok &&
		(idx == `IDX_PATH_FLAGS);

	// One wait state: capture in IDLE, complete in ACK
	always_comb
	begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			lpoh_pkg::BUS_IDLE:
				if (bus_req)
					bus_state_next = lpoh_pkg::BUS_ACK;
			lpoh_pkg::BUS_ACK:
				bus_state_next = lpoh_pkg::BUS_IDLE;
			default:
				bus_state_next = lpoh_pkg::BUS_IDLE;
		endcase
	end

	// Bus state register
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			bus_state_reg <= lpoh_pkg::BUS_IDLE;
		else
			bus_state_reg <= bus_state_next;
	end

	// Read multiplexer; unmapped and unused bits read zero
	always_comb
	begin
		read_mux = 8'h00;
		if (idx_ok)
		begin
			case (idx)
				`IDX_LINE_PAR_LOW: read_mux = parity_snap[7:0];
				`IDX_LINE_PAR_MID: read_mux = parity_snap[15:8];
				`IDX_LINE_PAR_HIGH: read_mux = {4'h0, parity_snap[19:16]};
				`IDX_LINE_FAR_LOW: read_mux = far_snap[7:0];
				`IDX_LINE_FAR_MID: read_mux = far_snap[15:8];
				`IDX_LINE_FAR_HIGH: read_mux = {4'h0, far_snap[19:16]};
				`IDX_RX_LINE_CTRL: read_mux[`FLD_PER_FRAME_MODE] = per_frame_mode_reg;
				`IDX_TX_LINE_CTRL: read_mux[`FLD_TX_REMOTE_DEFECT] = tx_rdi_reg;
				`IDX_TX_LINE_DIAG: read_mux[`FLD_PARITY_CORRUPT] = corrupt_reg;
				`IDX_PATH_STATUS:
				begin
					read_mux[`FLD_PATH_RDI] = PATH_REMOTE_DEFECT_STATE;
					read_mux[`FLD_PATH_AIS] = PATH_ALARM_STATE;
					read_mux[`FLD_POINTER_LOST] = POINTER_LOST_STATE;
				end
				`IDX_PATH_FLAGS: read_mux = flags_reg;
				`IDX_PATH_ENABLE: read_mux = enable_reg;
				`IDX_PATH_LABEL: read_mux = captured_reg;
				default: read_mux = 8'h00;
			endcase
		end
	end

	// Read data and the flags it shows are caught entering ACK
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			readdata_reg <= 32'h0000_0000;
			read_snap_reg <= 8'h00;
		end
		else if (bus_state_reg == lpoh_pkg::BUS_IDLE && AV_READ)
		begin
			readdata_reg <= {24'h00_0000, read_mux};
			read_snap_reg <= flags_reg;
		end
	end

	// Control registers written by software
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			per_frame_mode_reg <= `RST_CTRL_BIT;
			tx_rdi_reg <= `RST_CTRL_BIT;
			corrupt_reg <= `RST_CTRL_BIT;
			enable_reg <= `RST_ENABLE;
		end
		else if (wr_accept)
		begin
			case (idx)
				`IDX_RX_LINE_CTRL:
					per_frame_mode_reg <= AV_WRITEDATA[`FLD_PER_FRAME_MODE];
				`IDX_TX_LINE_CTRL:
					tx_rdi_reg <= AV_WRITEDATA[`FLD_TX_REMOTE_DEFECT];
				`IDX_TX_LINE_DIAG:
					corrupt_reg <= AV_WRITEDATA[`FLD_PARITY_CORRUPT];
				// Reserved enable bits are not stored and read zero
				`IDX_PATH_ENABLE:
					enable_reg <= AV_WRITEDATA[7:0] & `PATH_FLAG_MASK;
				default:
					enable_reg <= enable_reg;
			endcase
		end
	end

	// Any counter address write or the meter strobe polls both
	assign counter_poll = METER_LOAD || (wr_accept &&
		idx >= `IDX_LINE_PAR_LOW && idx <= `IDX_LINE_FAR_HIGH);

	// Per-frame mode caps parity at one count per errored frame
	always_comb
	begin
		parity_inc = '0;
		far_inc = '0;
		if (FRAME_PULSE)
		begin
			if (per_frame_mode_reg)
				parity_inc = {{(INC_W-1){1'b0}}, |LINE_PARITY_ERRS};
			else
				parity_inc = LINE_PARITY_ERRS;
			far_inc = LINE_FAR_ERRS;
		end
	end

	error_accumulator #(.W(CNT_W), .IW(INC_W)) parity_count_inst
	(
		.clk(CLK),
		.rst_n(rst_n_reg),
		.inc(parity_inc),
		.poll(counter_poll),
		.snapshot(parity_snap)
	);

	error_accumulator #(.W(CNT_W), .IW(INC_W)) far_count_inst
	(
		.clk(CLK),
		.rst_n(rst_n_reg),
		.inc(far_inc),
		.poll(counter_poll),
		.snapshot(far_snap)
	);

	// Transmit overhead overwrite, one register stage
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			TX_K2_OUT <= 8'h00;
			TX_B2_OUT <= 8'h00;
		end
		else
		begin
			// K2 bits 6..8 are the three least significant bits
			TX_K2_OUT <= tx_rdi_reg ? {TX_K2_IN[7:3], `RDI_K2_CODE} : TX_K2_IN;
			TX_B2_OUT <= corrupt_reg ? ~TX_B2_IN : TX_B2_IN;
		end
	end

	// Previous alarm states for change detection
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			rdi_prev_reg <= 1'b0;
			ais_prev_reg <= 1'b0;
			lop_prev_reg <= 1'b0;
		end
		else
		begin
			rdi_prev_reg <= PATH_REMOTE_DEFECT_STATE;
			ais_prev_reg <= PATH_ALARM_STATE;
			lop_prev_reg <= POINTER_LOST_STATE;
		end
	end

	// Label persistence: a value must repeat three frames running
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			cand_reg <= `RST_LABEL;
			run_reg <= 2'h0;
		end
		else if (FRAME_PULSE)
		begin
			if (RX_LABEL != cand_reg)
			begin
				cand_reg <= RX_LABEL;
				run_reg <= 2'h1;
			end
			else if (run_reg != `LABEL_FRAMES)
				run_reg <= run_reg + 2'h1;
		end
	end

	assign label_update = FRAME_PULSE && (RX_LABEL == cand_reg) &&
		(run_reg == `LABEL_FRAMES - 2'h1) && (RX_LABEL != captured_reg);

	// Captured label register
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			captured_reg <= `RST_LABEL;
		else if (label_update)
			captured_reg <= RX_LABEL;
	end

	// Event vector in the flags layout
	always_comb
	begin
		events = 8'h00;
		events[`FLD_PATH_FAR] = PATH_FAR_ERR;
		events[`FLD_PATH_PARITY] = PATH_PARITY_ERR;
		events[`FLD_PATH_RDI] = PATH_REMOTE_DEFECT_STATE ^ rdi_prev_reg;
		events[`FLD_PATH_AIS] = PATH_ALARM_STATE ^ ais_prev_reg;
		events[`FLD_POINTER_LOST] = POINTER_LOST_STATE ^ lop_prev_reg;
		events[`FLD_LABEL] = label_update;
	end

	// Sticky flags: only bits the read returned are cleared, and a
	// same-cycle event always wins over a clear
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			flags_reg <= 8'h00;
		else if (rd_flags)
			flags_reg <= (flags_reg & ~read_snap_reg) | events;
		else if (wr_accept && idx == `IDX_PATH_FLAG_CLEAR)
			flags_reg <= (flags_reg & ~AV_WRITEDATA[7:0]) | events;
		else
			flags_reg <= flags_reg | events;
	end

	// Level interrupt from enabled flags
	assign IRQ = |(flags_reg & enable_reg & `PATH_FLAG_MASK);

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!rst_n_reg);

	chk_k2_defect_code: assert property (tx_rdi_reg |=> TX_K2_OUT[2:0] == `RDI_K2_CODE)
		else $error("K2 remote defect code missing");
	chk_b2_inverted: assert property (corrupt_reg |=> TX_B2_OUT == ~$past(TX_B2_IN))
		else $error("B2 not inverted");
	chk_poll_in_time: assert property ((counter_poll && parity_inc == '0 &&
		far_inc == '0) |=> parity_snap == $past(parity_count_inst.acc_reg) &&
		far_snap == $past(far_count_inst.acc_reg))
		else $error("poll not served in time");
	chk_meter_load_polls: assert property (METER_LOAD |-> counter_poll)
		else $error("meter load did not poll");
	chk_frame_mode_cap: assert property ((per_frame_mode_reg && FRAME_PULSE) |-> parity_inc == (LINE_PARITY_ERRS != '0))
		else $error("per-frame mode counted more than one");
	chk_high_byte_zero: assert property ((bus_accept && AV_READ && (idx == `IDX_LINE_PAR_HIGH || idx == `IDX_LINE_FAR_HIGH)) |-> AV_READDATA[31:4] == 28'h0)
		else $error("upper counter bits not zero");
	chk_status_live: assert property ((bus_accept && AV_READ && idx_ok && idx == `IDX_PATH_STATUS) |-> AV_READDATA[`FLD_POINTER_LOST] == $past(POINTER_LOST_STATE))
		else $error("status not live");
	chk_parity_flag: assert property (PATH_PARITY_ERR |=> flags_reg[`FLD_PATH_PARITY])
		else $error("parity flag not set");
	chk_ais_change_flag: assert property ($changed(PATH_ALARM_STATE) |=> flags_reg[`FLD_PATH_AIS])
		else $error("AIS change not flagged");
	chk_label_flag: assert property ($changed(captured_reg) |-> flags_reg[`FLD_LABEL])
		else $error("label change not flagged");
	chk_read_clears: assert property ((rd_flags && events == 8'h00 && (flags_reg & ~read_snap_reg) == 8'h00) |=> flags_reg == 8'h00 && !IRQ)
		else $error("flags not cleared by read");
	chk_far_irq: assert property ((PATH_FAR_ERR && enable_reg[`FLD_PATH_FAR]) ##1 enable_reg[`FLD_PATH_FAR] |-> IRQ)
		else $error("far error interrupt missing");
	chk_lop_irq: assert property (($changed(POINTER_LOST_STATE) && enable_reg[`FLD_POINTER_LOST]) ##2 enable_reg[`FLD_POINTER_LOST] |-> IRQ)
		else $error("pointer lost interrupt missing");
	chk_label_persist: assert property ($changed(captured_reg) |-> captured_reg == $past(RX_LABEL) && $past(run_reg) == 2'h2)
		else $error("label taken before three frames");

	cov_flag_read: cover property (rd_flags && flags_reg != 8'h00);
	cov_label_change: cover property (label_update);
	cov_counter_poll: cover property (counter_poll && parity_snap != '0);
	cov_irq_rise: cover property ($rose(IRQ));
endmodule // sonet_line_path_oh_monitor
`default_nettype wire

// ---- sim/test_sonet_line_path_oh_monitor.sv ----
// Purpose: Self-checking bench for the line and path overhead monitor.
// Assumes: Bus accesses complete when waitrequest is seen low.
// Notes:   Random stimulus from a fixed seed, corner cases by hand.
`timescale 1ns/10ps
`default_nettype none
`include "lpoh_regs.svh"
module test_sonet_line_path_oh_monitor;
	// Clock, reset and bookkeeping
	logic clk;
	logic resetn;
	int n_fail;
	int cmp_count;
	int cycles;
	int seed;
	// Register bus
	logic [9:0] av_address;
	logic av_read;
	logic av_write;
	logic [31:0] av_writedata;
	logic [3:0] av_byteenable;
	logic [31:0] av_readdata;
	logic av_waitrequest;
	logic irq;
	// Receive side stimulus; alarm bits are defect, AIS, pointer lost
	logic meter_load;
	logic frame_pulse;
	logic [4:0] par_errs;
	logic [4:0] far_errs;
	logic path_par;
	logic path_far;
	logic [2:0] alarm;
	logic [7:0] rx_label;
	// Transmit bytes
	logic [7:0] k2_in;
	logic [7:0] b2_in;
	logic [7:0] k2_out;
	logic [7:0] b2_out;
	// Bench model of the counters and label
	logic [19:0] acc_par;
	logic [19:0] acc_far;
	logic [19:0] snap_par;
	logic [19:0] snap_far;
	logic per_frame;
	lpoh_pkg::reg_byte_t rd;
	lpoh_pkg::reg_byte_t label_now;

	sonet_line_path_oh_monitor DUT (
		.CLK(clk), .RESETN(resetn),
		.AV_ADDRESS(av_address), .AV_READ(av_read),
		.AV_WRITE(av_write), .AV_WRITEDATA(av_writedata),
		.AV_BYTEENABLE(av_byteenable), .AV_READDATA(av_readdata),
		.AV_WAITREQUEST(av_waitrequest), .IRQ(irq),
		.METER_LOAD(meter_load), .FRAME_PULSE(frame_pulse),
		.LINE_PARITY_ERRS(par_errs), .LINE_FAR_ERRS(far_errs),
		.PATH_PARITY_ERR(path_par), .PATH_FAR_ERR(path_far),
		.PATH_REMOTE_DEFECT_STATE(alarm[0]),
		.PATH_ALARM_STATE(alarm[1]), .POINTER_LOST_STATE(alarm[2]),
		.RX_LABEL(rx_label), .TX_K2_IN(k2_in), .TX_B2_IN(b2_in),
		.TX_K2_OUT(k2_out), .TX_B2_OUT(b2_out)
	);

	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Hang guard, well above the length of the whole sequence
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail = n_fail + 1;
			report_and_stop();
		end
	end

	// Compare one value
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One bus access; read data are taken at the completing edge
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, input logic [3:0] be, output logic [7:0] q);
		@(posedge clk);
		av_address <= {idx, 2'b00};
		av_read <= ~wr;
		av_write <= wr;
		av_writedata <= {24'h0, wd};
		av_byteenable <= be;
		// Hold everything until waitrequest is sampled low; only the
		// hang guard ends a wait that never finishes
		do
			@(posedge clk);
		while (av_waitrequest !== 1'b0);
		q = av_readdata[7:0];
		av_read <= 1'b0;
		av_write <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] idx, output logic [7:0] q);
		bus(1'b0, idx, 8'h00, 4'hf, q);
	endtask

	// A write to a counter address also polls the model
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, 4'hf, q);
		if (idx >= `IDX_LINE_PAR_LOW && idx <= `IDX_LINE_FAR_HIGH)
		begin
			snap_par = acc_par;
			snap_far = acc_far;
			acc_par = 20'h0;
			acc_far = 20'h0;
		end
	endtask

	// One frame of line errors and label; load polls in the same cycle
	task automatic frame(input logic [4:0] p, input logic [4:0] f,
		input logic [7:0] lab, input logic load);
		@(posedge clk);
		frame_pulse <= 1'b1;
		meter_load <= load;
		par_errs <= p;
		far_errs <= f;
		rx_label <= lab;
		acc_par = acc_par + (per_frame ? 20'(p != 5'h0) : 20'(p));
		acc_far = acc_far + 20'(f);
		if (load)
		begin
			snap_par = acc_par;
			snap_far = acc_far;
			acc_par = 20'h0;
			acc_far = 20'h0;
		end
		@(posedge clk);
		frame_pulse <= 1'b0;
		meter_load <= 1'b0;
	endtask

	// Read both counters over their three registers
	task automatic check_counts();
		logic [7:0] b [6];
		for (int i = 0; i < 6; i++)
			rd_reg(8'(`IDX_LINE_PAR_LOW + i), b[i]);
		check("parity count", {b[2], b[1], b[0]}, {4'h0, snap_par});
		check("far count", {b[5], b[4], b[3]}, {4'h0, snap_far});
	endtask

	// Bench expectations
	function automatic logic [7:0] k2_exp(logic [7:0] v, logic rdi);
		return rdi ? {v[7:3], `RDI_K2_CODE} : v;
	endfunction
	function automatic logic [7:0] status_exp(logic [2:0] a);
		return {2'b00, a[2], 1'b0, a[1], a[0], 2'b00};
	endfunction

	// Raise the event behind one flag bit
	task automatic raise(input int b);
		logic [7:0] nl;
		nl = label_now + 8'h11;
		@(posedge clk);
		case (b)
			0: path_far <= 1'b1;
			1: path_par <= 1'b1;
			2: alarm[0] <= ~alarm[0];
			3: alarm[1] <= ~alarm[1];
			5: alarm[2] <= ~alarm[2];
			default:
			begin
				// Two matches then a break must not update the label
				frame(5'h0, 5'h0, nl, 1'b0);
				frame(5'h0, 5'h0, nl, 1'b0);
				frame(5'h0, 5'h0, nl ^ 8'h01, 1'b0);
				rd_reg(`IDX_PATH_LABEL, rd);
				check("label held", rd, label_now);
				repeat (3) frame(5'h0, 5'h0, nl, 1'b0);
				label_now = nl;
				rd_reg(`IDX_PATH_LABEL, rd);
				check("label taken", rd, label_now);
			end
		endcase
		@(posedge clk);
		path_far <= 1'b0;
		path_par <= 1'b0;
	endtask

	// Main sequence
	initial
	begin
		logic [7:0] k;
		logic [7:0] b;
		int r;
		int bits [6] = '{0, 1, 2, 3, 5, 7};
		n_fail = 0;
		cmp_count = 0;
		cycles = 0;
		seed = 69546;
		resetn = 1'b0;
		{av_address, av_read, av_write, av_writedata} = '0;
		av_byteenable = 4'hf;
		{meter_load, frame_pulse, par_errs, far_errs} = '0;
		{path_par, path_far, alarm, rx_label, k2_in, b2_in} = '0;
		{acc_par, acc_far, snap_par, snap_far, per_frame} = '0;
		label_now = `RST_LABEL;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values, reserved bits, refused accesses
		rd_reg(`IDX_PATH_ENABLE, rd);
		check("enable reset", rd, `RST_ENABLE);
		rd_reg(`IDX_PATH_LABEL, rd);
		check("label reset", rd, `RST_LABEL);
		rd_reg(8'h3f, rd);
		check("unmapped read", rd, 8'h00);
		bus(1'b1, `IDX_PATH_ENABLE, 8'hff, 4'h0, rd);
		rd_reg(`IDX_PATH_ENABLE, rd);
		check("masked write", rd, 8'h00);
		wr_reg(`IDX_PATH_ENABLE, 8'hff);
		rd_reg(`IDX_PATH_ENABLE, rd);
		check("enable bits", rd, `PATH_FLAG_MASK);
		// Counters in both modes, meter load coinciding with a frame
		for (int m = 0; m < 2; m++)
		begin
			per_frame = 1'(m);
			wr_reg(`IDX_RX_LINE_CTRL, m ? 8'h80 : 8'h00);
			rd_reg(`IDX_RX_LINE_CTRL, rd);
			check("mode readback", rd, m ? 8'h80 : 8'h00);
			wr_reg(`IDX_LINE_PAR_MID, 8'h00);
			repeat (40)
			begin
				r = $unsigned($random(seed)) % 36;
				frame(r > 24 ? 5'h0 : 5'(r), 5'($unsigned($random(seed)) % 25),
					label_now, 1'b0);
			end
			frame(5'd24, 5'd24, label_now, 1'b1);
			check_counts();
			repeat (5) frame(5'd7, 5'd3, label_now, 1'b0);
			wr_reg(`IDX_LINE_FAR_HIGH, 8'h00);
			check_counts();
			wr_reg(`IDX_LINE_PAR_LOW, 8'h00);
			check_counts();
		end
		// Transmit overwrite controls, every combination
		for (int m = 0; m < 4; m++)
		begin
			wr_reg(`IDX_TX_LINE_CTRL, {7'h0, 1'(m)});
			wr_reg(`IDX_TX_LINE_DIAG, {7'h0, 1'(m >> 1)});
			rd_reg(`IDX_TX_LINE_DIAG, rd);
			check("diag readback", rd, {7'h0, 1'(m >> 1)});
			rd_reg(`IDX_TX_LINE_CTRL, rd);
			check("ctrl readback", rd, {7'h0, 1'(m)});
			repeat (8)
			begin
				k = 8'($random(seed));
				b = 8'($random(seed));
				@(posedge clk);
				k2_in <= k;
				b2_in <= b;
				@(posedge clk);
				@(negedge clk);
				check("k2 out", k2_out, k2_exp(k, 1'(m)));
				// Cast keeps the inversion at byte width
				check("b2 out", b2_out, m >> 1 ? 8'(~b) : b);
			end
		end
		// Event flags, each unmasked and masked
		rd_reg(`IDX_PATH_FLAGS, rd);
		foreach (bits[i])
		begin
			for (int m = 1; m >= 0; m--)
			begin
				wr_reg(`IDX_PATH_ENABLE, m ? 8'h01 << bits[i] : 8'h00);
				raise(bits[i]);
				repeat (3) @(negedge clk);
				check("irq level", irq, m);
				rd_reg(`IDX_PATH_STATUS, rd);
				check("path status", rd, status_exp(alarm));
				rd_reg(`IDX_PATH_FLAGS, rd);
				check("flags", rd, 8'h01 << bits[i]);
				@(negedge clk);
				check("irq cleared", irq, 0);
				rd_reg(`IDX_PATH_FLAGS, rd);
				check("flags cleared", rd, 8'h00);
			end
		end
		// Write-one clear register drops only the bits written
		raise(0);
		raise(1);
		wr_reg(`IDX_PATH_FLAG_CLEAR, 8'h01);
		rd_reg(`IDX_PATH_FLAGS, rd);
		check("flag clear", rd, 8'h02);
		report_and_stop();
	end
endmodule // test_sonet_line_path_oh_monitor
`default_nettype wire
